/* File: design/rbs_sequencer.sv */
// reset and boot sequencer: reset release, core power, strap capture,
// enable-pin debounce, brownout and thermal protection
// assumes analog comparators and temperature code arrive synchronous
// How it works
// - release reset when supply good and enable high
// - enable core regulator on release, ready later
// - sample test strap within 4 ms of release
// - sample download strap within 5 ms of ready
// - sample flash strap within 5 ms of ready
// - without pseudo-static memory flash is always NOR
// - straps captured once per power-on or enable reset
// - pull-ups on before straps are captured
// - enable debounce programmable 0 us to 16 ms
// - brownout starts enabled in reset mode
// - brownout reset holds reset and disables pads
// - brownout reset keeps captured strap values
// - rising and falling levels selectable, defaults 5/8
// - brownout needs supply low for 1 ms
// - high temperature crossing raises its flag
// - low temperature crossing raises its flag
// - over-temperature trips thermal reset by itself
// - thermal hold 500 ms, recheck against 125 C
// - warning and protection have own enables, thresholds
`timescale 1ns/1ps
module rbs_sequencer
   import rbs_pkg::*;
#(
   parameter bit HAS_PSRAM = 1'b1,
   parameter int CORE_N = CORE_CYC,
   parameter int BOD_N = BOD_CYC,
   parameter int THERM_N = THERM_CYC
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // supply monitor and enable pin
   input wire logic i_supply_por_ok,
   input wire logic [BOD_LEVELS-1:0] i_bod_cmp,
   input wire logic i_chip_en,
   // strap pins
   input wire logic i_test_mode_disable_strap,
   input wire logic i_download_disable_strap,
   input wire logic i_flash_type_strap,
   output logic o_strap_pullup_en,
   // configuration
   input wire logic i_cfg_wr,
   input wire rbs_cfg_t i_cfg,
   output rbs_cfg_t o_cfg,
   // thermal
   input wire logic signed [7:0] i_temp,
   input wire rbs_therm_t i_therm,
   // event flags
   input wire rbs_irq_t i_irq_clr,
   output rbs_irq_t o_irq,
   // sequence outputs
   output logic o_sys_rst_b,
   output logic o_core_reg_en,
   output logic o_core_ready,
   output logic o_pad_out_dis,
   output logic o_therm_rst,
   output rbs_strap_t o_straps,
   output logic o_straps_valid
);

   typedef struct packed {
      rbs_st_t st;
      logic [CNT_W-1:0] cnt;
      rbs_strap_t straps;
      logic straps_done;
      rbs_cfg_t cfg;
      rbs_irq_t irq;
      logic hi_prev;
      logic lo_prev;
      logic bod_prev;
   } rbs_seq_st_t;

   localparam rbs_seq_st_t S_RST = '{st: RBS_ST_RESET, cnt: '0,
      straps: '0, straps_done: 1'b0, cfg: CFG_RST, irq: '0,
      hi_prev: 1'b0, lo_prev: 1'b0, bod_prev: 1'b0};

   rbs_seq_st_t s_r;
   rbs_seq_st_t s_nxt;
   logic en_rst;
   logic bod_held;
   logic bod_low;
   logic rise_ok;
   logic rst_req;
   logic released;
   logic otp_over;
   logic bod_trip;
   logic hi_now;
   logic lo_now;
   logic tm_take;
   logic boot_take;
   logic [DBC_W-1:0] dbc_len;
   rbs_irq_t irq_set;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);

   // ---------------------------------------------------------------
   // level select decode
   // ---------------------------------------------------------------
   function automatic logic lvl_above(input logic [3:0] sel,
                                      input logic [3:0] dflt,
                                      input logic [BOD_LEVELS-1:0] cmp);
      logic [3:0] idx;
      idx = (sel >= 4'h1 && sel <= 4'(BOD_LEVELS)) ? sel : dflt;
      return cmp[idx-4'h1];
   endfunction : lvl_above

   // ---------------------------------------------------------------
   // enable pin debounce and brownout filter
   // ---------------------------------------------------------------
   always_comb begin
      dbc_len = DBC_W'(s_r.cfg.dbc_us > DBC_MAX_US ? DBC_MAX_US
                                                   : s_r.cfg.dbc_us);
      dbc_len = DBC_W'(dbc_len * DBC_W'(CYC_PER_US));
   end

   rbs_hold #(.W(DBC_W)) u_en_dbc (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_lvl(!i_chip_en),
      .i_len(dbc_len),
      .o_held(en_rst)
   );

   // falling level below, filtered for the minimum low time
   assign bod_low = s_r.cfg.bod_en &&
      !lvl_above(s_r.cfg.fall_sel, BOD_FALL_DEF, i_bod_cmp);
   assign rise_ok = !s_r.cfg.bod_en ||
      lvl_above(s_r.cfg.rise_sel, BOD_RISE_DEF, i_bod_cmp);

   rbs_hold #(.W(DBC_W)) u_bod_flt (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_lvl(bod_low),
      .i_len(DBC_W'(BOD_N - 1)),
      .o_held(bod_held)
   );

   // ---------------------------------------------------------------
   // reset sources and thermal comparisons
   // ---------------------------------------------------------------
   assign rst_req = !i_supply_por_ok || en_rst;
   assign released = s_r.st inside {RBS_ST_PULL_TM, RBS_ST_CORE,
                                    RBS_ST_PULL_BOOT, RBS_ST_RUN};
   assign otp_over = i_therm.otp_en && (i_temp > i_therm.otp_thr);
   assign bod_trip = !s_r.cfg.bod_irq_mode && bod_held;
   assign hi_now = i_therm.hi_en && (i_temp > i_therm.hi_thr);
   assign lo_now = i_therm.lo_en && (i_temp < i_therm.lo_thr);

   always_comb begin
      irq_set.temp_hi = hi_now && !s_r.hi_prev;
      irq_set.temp_lo = lo_now && !s_r.lo_prev;
      irq_set.bod = s_r.cfg.bod_irq_mode && bod_held &&
                    !s_r.bod_prev;
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      tm_take = 1'b0;
      boot_take = 1'b0;
      s_nxt.cnt = CNT_W'(s_r.cnt + 1'b1);
      if (i_cfg_wr) begin
         s_nxt.cfg = i_cfg;
      end
      s_nxt.hi_prev = hi_now;
      s_nxt.lo_prev = lo_now;
      s_nxt.bod_prev = bod_held;
      // set wins over clear
      s_nxt.irq = irq_set | (s_r.irq & ~i_irq_clr);
      if (rst_req) begin
         s_nxt.st = RBS_ST_RESET;
         s_nxt.straps_done = 1'b0;
      end else if (released && otp_over) begin
         s_nxt.st = RBS_ST_THERM;
         s_nxt.cnt = '0;
      end else if (released && bod_trip) begin
         s_nxt.st = RBS_ST_BROWNOUT;
      end else begin
         case (s_r.st)
            RBS_ST_RESET: begin
               if (i_chip_en) begin
                  s_nxt.cnt = '0;
                  s_nxt.st = s_r.straps_done ? RBS_ST_CORE
                                             : RBS_ST_PULL_TM;
               end
            end
            RBS_ST_PULL_TM: begin
               if (s_r.cnt == CNT_W'(PULL_CYC - 1)) begin
                  tm_take = 1'b1;
                  s_nxt.straps.test_mode =
                     !i_test_mode_disable_strap;
                  s_nxt.st = RBS_ST_CORE;
                  s_nxt.cnt = '0;
               end
            end
            RBS_ST_CORE: begin
               if (s_r.cnt == CNT_W'(CORE_N - 1)) begin
                  s_nxt.cnt = '0;
                  s_nxt.st = s_r.straps_done ? RBS_ST_RUN
                                             : RBS_ST_PULL_BOOT;
               end
            end
            RBS_ST_PULL_BOOT: begin
               if (s_r.cnt == CNT_W'(PULL_CYC - 1)) begin
                  boot_take = 1'b1;
                  s_nxt.straps.download_mode =
                     !i_download_disable_strap;
                  s_nxt.straps.nand_flash =
                     HAS_PSRAM && !i_flash_type_strap;
                  s_nxt.straps_done = 1'b1;
                  s_nxt.st = RBS_ST_RUN;
               end
            end
            RBS_ST_RUN: begin
               s_nxt.cnt = s_r.cnt;
            end
            RBS_ST_BROWNOUT: begin
               if (rise_ok) begin
                  s_nxt.st = RBS_ST_RESET;
               end
            end
            RBS_ST_THERM: begin
               if (s_r.cnt == CNT_W'(THERM_N - 1)) begin
                  s_nxt.cnt = '0;
                  if (i_temp < OTP_CHECK_C) begin
                     s_nxt.st = RBS_ST_RESET;
                  end
               end
            end
            default: begin
               s_nxt.st = RBS_ST_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_r <= S_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_sys_rst_b = released;
   assign o_core_reg_en = released;
   assign o_core_ready = s_r.st inside {RBS_ST_PULL_BOOT, RBS_ST_RUN};
   assign o_strap_pullup_en =
      s_r.st inside {RBS_ST_PULL_TM, RBS_ST_PULL_BOOT};
   assign o_pad_out_dis = (s_r.st == RBS_ST_BROWNOUT);
   assign o_therm_rst = (s_r.st == RBS_ST_THERM);
   assign o_straps = s_r.straps;
   assign o_straps_valid = s_r.straps_done;
   assign o_cfg = s_r.cfg;
   assign o_irq = s_r.irq;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence strap_take_s;
      tm_take || boot_take;
   endsequence

   sequence pull_held_s;
      o_strap_pullup_en && $past(o_strap_pullup_en);
   endsequence

   release_a: assert property (
      (s_r.st == RBS_ST_RESET && i_chip_en && !rst_req)
      |=> o_sys_rst_b)
      else $error("reset not released with supply and enable good");

   core_on_a: assert property (
      $rose(o_sys_rst_b) |-> o_core_reg_en ##1 o_core_reg_en)
      else $error("core regulator not enabled on reset release");

   core_time_a: assert property (
      $rose(o_core_ready)
      |-> $past(s_r.cnt) == CNT_W'(CORE_N - 1))
      else $error("core ready at wrong time");

   tm_time_a: assert property (
      tm_take |-> o_sys_rst_b && (s_r.cnt < CNT_W'(TM_CYC)))
      else $error("test strap sampled late");

   boot_time_a: assert property (
      boot_take |-> o_core_ready && (s_r.cnt < CNT_W'(UD_CYC))
                    && (s_r.cnt < CNT_W'(NOR_CYC)))
      else $error("boot straps sampled late");

   nor_only_a: assert property (
      !HAS_PSRAM |-> !o_straps.nand_flash)
      else $error("nand reported without pseudo-static memory");

   strap_keep_a: assert property (
      (s_r.straps_done && $past(s_r.straps_done)) |-> $stable(o_straps))
      else $error("straps changed after capture");

   pull_first_a: assert property (
      strap_take_s |-> pull_held_s)
      else $error("strap captured without pull-ups");

   brownout_pads_a: assert property (
      o_pad_out_dis |-> !o_sys_rst_b && !o_core_ready ##1
      (o_pad_out_dis || !o_sys_rst_b))
      else $error("brownout reset not holding reset and pads");

   brownout_cause_a: assert property (
      $rose(o_pad_out_dis) |-> $past(bod_held)
      && !$past(s_r.cfg.bod_irq_mode))
      else $error("brownout reset without filtered low supply");

   temp_hi_a: assert property (
      (hi_now && !s_r.hi_prev) |=> o_irq.temp_hi)
      else $error("high temperature flag missed");

   temp_lo_a: assert property (
      (lo_now && !s_r.lo_prev) |=> o_irq.temp_lo)
      else $error("low temperature flag missed");

   otp_trip_a: assert property (
      (released && otp_over && !rst_req) |=> o_therm_rst)
      else $error("over-temperature did not trip thermal reset");

   therm_hold_a: assert property (
      (o_therm_rst && !rst_req && s_r.cnt != CNT_W'(THERM_N - 1))
      |=> o_therm_rst)
      else $error("thermal reset left before hold time");

   therm_exit_a: assert property (
      (o_therm_rst && !rst_req && s_r.cnt == CNT_W'(THERM_N - 1))
      |=> (s_r.st == RBS_ST_RESET) == ($past(i_temp) < OTP_CHECK_C))
      else $error("thermal recheck decision wrong");

   bod_irq_a: assert property (
      irq_set.bod |=> o_irq.bod && !$rose(o_pad_out_dis))
      else $error("brownout interrupt flag missed");

endmodule : rbs_sequencer

/* File: design/rbs_pkg.sv */
// reset and boot sequencer: shared constants, timing counts and types
// assumes one 50 MHz clock; counts derive from the times below
package rbs_pkg;

   // ---------------------------------------------------------------
   // clock and times
   // ---------------------------------------------------------------
   localparam real CLK_MHZ = 50.0;
   localparam int CYC_PER_US = int'(CLK_MHZ);
   localparam real T_CORE_MS = 4.8;
   localparam real T_TM_MS = 4.0;
   localparam real T_UD_MS = 5.0;
   localparam real T_NOR_MS = 5.0;
   localparam real T_PULL_US = 10.0;
   localparam real T_DBC_DEF_MS = 0.1;
   localparam real T_DBC_MAX_MS = 16.0;
   localparam real T_RST_BOD_MS = 1.0;
   localparam real T_THERM_MS = 500.0;

   // ---------------------------------------------------------------
   // cycle counts (least times round up, longest round down)
   // ---------------------------------------------------------------
   localparam int CORE_CYC = int'($ceil(T_CORE_MS * CLK_MHZ * 1000.0));
   localparam int TM_CYC = int'($floor(T_TM_MS * CLK_MHZ * 1000.0));
   localparam int UD_CYC = int'($floor(T_UD_MS * CLK_MHZ * 1000.0));
   localparam int NOR_CYC = int'($floor(T_NOR_MS * CLK_MHZ * 1000.0));
   localparam int PULL_CYC = int'($ceil(T_PULL_US * CLK_MHZ));
   localparam int BOD_CYC = int'($ceil(T_RST_BOD_MS * CLK_MHZ * 1000.0));
   localparam int THERM_CYC = int'($ceil(T_THERM_MS * CLK_MHZ * 1000.0));

   // ---------------------------------------------------------------
   // widths, levels and reset values
   // ---------------------------------------------------------------
   localparam int CNT_W = 25;
   localparam int DBC_W = 20;
   localparam int BOD_LEVELS = 10;
   localparam logic [13:0] DBC_DEF_US = 14'(int'(T_DBC_DEF_MS * 1000.0));
   localparam logic [13:0] DBC_MAX_US = 14'(int'(T_DBC_MAX_MS * 1000.0));
   localparam logic [3:0] BOD_RISE_DEF = 4'h5;
   localparam logic [3:0] BOD_FALL_DEF = 4'h8;
   localparam logic signed [7:0] OTP_CHECK_C = 8'sh7d;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [6:0] {
      RBS_ST_RESET = 7'h01,
      RBS_ST_PULL_TM = 7'h02,
      RBS_ST_CORE = 7'h04,
      RBS_ST_PULL_BOOT = 7'h08,
      RBS_ST_RUN = 7'h10,
      RBS_ST_BROWNOUT = 7'h20,
      RBS_ST_THERM = 7'h40
   } rbs_st_t;

   typedef struct packed {
      logic bod_en;
      logic bod_irq_mode;
      logic [3:0] rise_sel;
      logic [3:0] fall_sel;
      logic [13:0] dbc_us;
   } rbs_cfg_t;

   typedef struct packed {
      logic hi_en;
      logic lo_en;
      logic otp_en;
      logic signed [7:0] hi_thr;
      logic signed [7:0] lo_thr;
      logic signed [7:0] otp_thr;
   } rbs_therm_t;

   typedef struct packed {
      logic test_mode;
      logic download_mode;
      logic nand_flash;
   } rbs_strap_t;

   typedef struct packed {
      logic temp_hi;
      logic temp_lo;
      logic bod;
   } rbs_irq_t;

   localparam rbs_cfg_t CFG_RST = '{bod_en: 1'b1, bod_irq_mode: 1'b0,
      rise_sel: BOD_RISE_DEF, fall_sel: BOD_FALL_DEF, dbc_us: DBC_DEF_US};

endpackage : rbs_pkg

/* File: design/rbs_hold.sv */
// level hold filter: reports a level that has stayed high i_len + 1 cycles
// assumes i_lvl is synchronous to i_ref_clk
`timescale 1ns/1ps
module rbs_hold
   import rbs_pkg::*;
#(
   parameter int W = DBC_W
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // level and length
   input wire logic i_lvl,
   input wire logic [W-1:0] i_len,
   // filtered result
   output logic o_held
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic held;
   } rbs_hold_st_t;

   rbs_hold_st_t s_r;
   rbs_hold_st_t s_nxt;

   // ---------------------------------------------------------------
   // saturating run counter
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      if (!i_lvl) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt != {W{1'b1}}) begin
         s_nxt.cnt = W'(s_r.cnt + 1'b1);
      end
      s_nxt.held = i_lvl && (s_r.cnt >= i_len);
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_held = s_r.held;

   held_cause_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_held |-> $past(i_lvl) && ($past(s_r.cnt) >= $past(i_len)))
      else $error("hold output without a long enough level");

endmodule : rbs_hold

/* File: sim/rbs_far.sv */
// far side model: supply with comparator ladder and strap pins
// assumes the bench sets the supply in millivolts and the strap drives
`timescale 1ns/1ps
module rbs_far
   import rbs_pkg::*;
(
   // clock and bench controls
   input wire logic i_ref_clk,
   input wire logic [11:0] i_mv,
   input wire logic [2:0] i_drv_en,
   input wire logic [2:0] i_drv_val,
   input wire logic i_pullup_en,
   // lines toward the sequencer
   output logic o_por_ok,
   output logic [BOD_LEVELS-1:0] o_bod_cmp,
   output logic [2:0] o_strap
);
   localparam int POR_MV = 2100;
   localparam int LV [BOD_LEVELS] = '{2840, 2800, 2770, 2730, 2690,
      2630, 2590, 2550, 2510, 2470};
   logic flip_r = 1'b0;

   always @(posedge i_ref_clk) begin
      flip_r <= ~flip_r;
   end

   always_comb begin
      o_por_ok = int'(i_mv) > POR_MV;
      for (int k = 0; k < BOD_LEVELS; k++) begin
         o_bod_cmp[k] = int'(i_mv) > LV[k];
      end
      for (int s = 0; s < 3; s++) begin
         // undriven pin without pull-up wanders every cycle
         o_strap[s] = i_drv_en[s] ? i_drv_val[s] : (i_pullup_en | flip_r);
      end
   end
endmodule : rbs_far

/* File: sim/tb.sv */
// bench for the reset and boot sequencer: power-up, straps, brownout,
// enable debounce and thermal cases against a far side model
// assumes shortened counts handed to the sequencer as parameters
`timescale 1ns/1ps
module tb
   import rbs_pkg::*;
;
   localparam int CN = 20;
   localparam int BN = 10;
   localparam int TN = 30;
   localparam int LV [BOD_LEVELS] = '{2840, 2800, 2770, 2730, 2690,
      2630, 2590, 2550, 2510, 2470};
   logic clk = 1'b0;
   logic rst_b, chip_en, cfg_wr, por_ok, pull, sys, creg, crdy, pdis;
   logic trst, sval;
   logic [11:0] mv;
   logic [2:0] drv_en, drv_val, strap;
   logic [BOD_LEVELS-1:0] cmp;
   logic signed [7:0] temp;
   rbs_cfg_t cfg, ocfg;
   rbs_therm_t therm;
   rbs_irq_t clr, irq;
   rbs_strap_t st;
   rbs_strap_t st_nor;
   int num_errors = 0;
   int checks = 0;
   logic [31:0] seed = 32'h0000_00d9;

   always #10 clk = ~clk;

   rbs_far far (.i_ref_clk(clk), .i_mv(mv), .i_drv_en(drv_en),
      .i_drv_val(drv_val), .i_pullup_en(pull), .o_por_ok(por_ok),
      .o_bod_cmp(cmp), .o_strap(strap));

   rbs_sequencer #(.HAS_PSRAM(1'b1), .CORE_N(CN), .BOD_N(BN),
      .THERM_N(TN)) dut (
      .i_ref_clk(clk), .i_rst_b(rst_b), .i_supply_por_ok(por_ok),
      .i_bod_cmp(cmp), .i_chip_en(chip_en),
      .i_test_mode_disable_strap(strap[2]),
      .i_download_disable_strap(strap[1]),
      .i_flash_type_strap(strap[0]), .o_strap_pullup_en(pull),
      .i_cfg_wr(cfg_wr), .i_cfg(cfg), .o_cfg(ocfg), .i_temp(temp),
      .i_therm(therm), .i_irq_clr(clr), .o_irq(irq),
      .o_sys_rst_b(sys), .o_core_reg_en(creg), .o_core_ready(crdy),
      .o_pad_out_dis(pdis), .o_therm_rst(trst), .o_straps(st),
      .o_straps_valid(sval));

   // same sequencer built without pseudo-static memory
   rbs_sequencer #(.HAS_PSRAM(1'b0), .CORE_N(CN), .BOD_N(BN),
      .THERM_N(TN)) dut_nor (
      .i_ref_clk(clk), .i_rst_b(rst_b), .i_supply_por_ok(por_ok),
      .i_bod_cmp(cmp), .i_chip_en(chip_en),
      .i_test_mode_disable_strap(strap[2]),
      .i_download_disable_strap(strap[1]),
      .i_flash_type_strap(strap[0]), .o_strap_pullup_en(),
      .i_cfg_wr(cfg_wr), .i_cfg(cfg), .o_cfg(), .i_temp(temp),
      .i_therm(therm), .i_irq_clr(clr), .o_irq(), .o_sys_rst_b(),
      .o_core_reg_en(), .o_core_ready(), .o_pad_out_dis(),
      .o_therm_rst(), .o_straps(st_nor), .o_straps_valid());

   // ----------
   // helpers
   // ----------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // pin levels to captured modes, every mode active on a low pin
   function automatic logic [2:0] st_exp(input logic [2:0] lvl);
      return ~lvl;
   endfunction : st_exp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic end_sim();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   task automatic set_cfg(input rbs_cfg_t c);
      cfg = c;
      cfg_wr = 1'b1;
      cyc(1);
      cfg_wr = 1'b0;
      cyc(1);
      chk(ocfg, c);
   endtask : set_cfg

   task automatic clear(input rbs_irq_t m);
      clr = m;
      cyc(1);
      clr = '0;
      cyc(2);
      chk(irq & m, 3'h0);
   endtask : clear

   // waits for release, core power and strap capture
   task automatic boot(input logic [2:0] exp, input logic fresh);
      int n;
      n = 0;
      while (sys !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      chk({sys, creg, pull}, {2'h3, fresh});
      n = 0;
      while (crdy !== 1'b1 && n < 2000) begin
         cyc(1);
         n++;
      end
      chk(n >= CN && n <= PULL_CYC + CN + 1, 1'b1);
      n = 0;
      while (sval !== 1'b1 && n < 2000) begin
         cyc(1);
         n++;
      end
      chk({n <= UD_CYC, sval, pull}, 3'h6);
      chk({st, pdis}, {exp, 1'b0});
   endtask : boot

   // ----------
   // main sequence
   // ----------
   initial begin
      int f, r;
      rst_b = 1'b0;
      chip_en = 1'b0;
      cfg_wr = 1'b0;
      mv = 12'h000;
      drv_en = 3'h0;
      drv_val = 3'h0;
      temp = 8'h19;
      cfg = '0;
      therm = '0;
      clr = '0;
      cyc(20);
      chk({pull, sys, creg, crdy, pdis, trst, sval}, 7'h00);
      chk(ocfg.bod_en & ~ocfg.bod_irq_mode, 1'b1);
      chk({ocfg.rise_sel, ocfg.fall_sel}, 8'h58);
      chk(ocfg.dbc_us, 14'h0064);
      rst_b = 1'b1;
      chip_en = 1'b1;
      cyc(5);
      chk(sys, 1'b0);
      mv = 12'hce4;
      boot(st_exp(3'h7), 1'b1);
      // short dip, then a long one with straps now pulled low
      mv = 12'h9c4;
      cyc(BN - 3);
      mv = 12'hce4;
      cyc(5);
      chk({sys, pdis}, 2'h2);
      drv_en = 3'h7;
      mv = 12'h9c4;
      cyc(BN + 3);
      chk({sys, pdis, creg}, 3'h2);
      mv = 12'ha28;
      cyc(20);
      chk(sys, 1'b0);
      mv = 12'hce4;
      boot(st_exp(3'h7), 1'b0);
      drv_en = 3'h0;
      for (int i = 0; i < 4; i++) begin
         f = 7 + int'(rnd() % 4);
         r = 1 + int'(rnd() % 5);
         set_cfg('{1'b1, 1'b1, 4'(r), 4'(f), 14'h0064});
         mv = 12'(LV[f-1] + 10);
         cyc(BN + 3);
         chk(irq.bod, 1'b0);
         mv = 12'(LV[f-1] - 20);
         cyc(BN + 3);
         chk({irq.bod, sys, pdis}, 3'h6);
         mv = 12'hce4;
         clear(3'h1);
      end
      set_cfg('{1'b0, 1'b0, 4'h5, 4'h8, 14'h0064});
      mv = 12'h9c4;
      cyc(BN + 5);
      chk({irq.bod, sys}, 2'h1);
      mv = 12'hce4;
      set_cfg('{1'b1, 1'b0, 4'h5, 4'h8, 14'h0001});
      chip_en = 1'b0;
      cyc(45);
      chip_en = 1'b1;
      cyc(3);
      chk(sys, 1'b1);
      drv_en = 3'h7;
      chip_en = 1'b0;
      cyc(45);
      chk(sys, 1'b1);
      cyc(5100);
      chk(sys, 1'b0);
      chip_en = 1'b1;
      boot(st_exp(3'h0), 1'b1);
      chk(st_nor, 3'h6);
      drv_en = 3'h0;
      therm = '{1'b1, 1'b1, 1'b1, 8'h50, 8'hf6, 8'h6e};
      temp = 8'h5a;
      cyc(3);
      chk(irq, 3'h4);
      clear(3'h4);
      temp = 8'hec;
      cyc(3);
      chk(irq, 3'h2);
      clear(3'h2);
      therm.hi_en = 1'b0;
      temp = 8'h5a;
      cyc(3);
      chk(irq, 3'h0);
      temp = 8'h7e;
      cyc(2);
      chk({trst, sys}, 2'h2);
      cyc(TN + 5);
      chk({trst, sys}, 2'h2);
      temp = 8'h64;
      boot(st_exp(3'h0), 1'b0);
      chk(trst, 1'b0);
      end_sim();
   end

   initial begin
      cyc(40000);
      num_errors++;
      end_sim();
   end
endmodule : tb
